/* File: core/sysreg_pkg.sv */
// constants and types for the system pin and identification register group
// assumes byte-wide register offsets decoded ahead of this block
package sysreg_pkg;

   // register offsets
   localparam logic [7:0] OFS_STATUS    = 8'h00;
   localparam logic [7:0] OFS_MASK      = 8'h01;
   localparam logic [7:0] OFS_AUX_CTL   = 8'h02;
   localparam logic [7:0] OFS_FIFO_THR  = 8'h06;
   localparam logic [7:0] OFS_IDENT     = 8'h08;
   localparam logic [7:0] OFS_BUS_ADDR  = 8'h09;
   localparam logic [7:0] OFS_RATIO     = 8'h0A;
   localparam logic [7:0] OFS_AUX1_FN   = 8'h0B;
   localparam logic [7:0] OFS_RATIO_CTL = 8'h50;

   // field positions
   localparam int B_FIFO_FLUSH = 15;
   localparam int B_SLOT_B     = 6;
   localparam int B_SLOT_A     = 5;
   localparam int B_FIFO_MASK  = 8;
   localparam int B_AUX1_DRV   = 9;
   localparam int B_AUX1_POL   = 8;
   localparam int B_AUX0_EN    = 2;
   localparam int B_AUX0_DRV   = 1;
   localparam int B_AUX0_POL   = 0;
   localparam int B_RATIO_EN   = 5;
   localparam int THR_LSB      = 8;
   localparam int THR_W        = 6;
   localparam int KEY_LSB      = 8;
   localparam int ADDR_LSB     = 1;
   localparam int ADDR_W       = 7;
   localparam int FN_LSB       = 8;
   localparam int FN_W         = 5;
   localparam int RATIO_W      = 12;

   // reset values and keys
   localparam logic [8:0]  MASK_RST     = 9'h1FF;
   localparam logic [6:0]  BUS_ADDR_RST = 7'h64;
   localparam logic [7:0]  ADDR_KEY     = 8'hAD;
   localparam logic [11:0] RATIO_NOM    = 12'h7D0;
   localparam logic [1:0]  SLOW_PERIODS = 2'h2;

   // second auxiliary pin functions
   typedef enum logic [4:0] {
      FN_LEGACY   = 5'h00,
      FN_IRQ      = 5'h01,
      FN_SLOTS    = 5'h02,
      FN_PULSE_A  = 5'h05,
      FN_PULSE_B  = 5'h06,
      FN_PULSE_AB = 5'h07,
      FN_DATA_A   = 5'h0C,
      FN_DATA_B   = 5'h0D,
      FN_DATA_ANY = 5'h0E,
      FN_TOGGLE   = 5'h0F,
      FN_LOW      = 5'h10,
      FN_HIGH     = 5'h11
   } aux1_func_t;

endpackage

/* File: core/aux_pin_if.sv */
// carrier between the register group and one auxiliary pin driver
// assumes the owner fills the settings every cycle
interface aux_pin_if;
   logic enable;
   logic drive_mode;
   logic polarity;
   logic active;
   logic pin_out;
   logic pin_oe;

   modport ctl (output enable, drive_mode, polarity, active, input pin_out, pin_oe);
   modport drv (input enable, drive_mode, polarity, active, output pin_out, pin_oe);
endinterface

/* File: core/aux_pin_drive.sv */
// one auxiliary output pin: polarity, push-pull or open-drain, enable
// assumes the pad resolves the level from pin_out and pin_oe
module aux_pin_drive (
   input wire logic clk,
   input wire logic rstn,
   aux_pin_if.drv   p
);

   logic out_r;
   logic oe_r;

   // registered pad level and enable; floats out of reset
   // open drain enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_r <= 1'b0;
         oe_r  <= 1'b0;
      end else begin
         out_r <= p.active ^ p.polarity;
         oe_r  <= p.enable & (~p.drive_mode | p.active);
      end
   end

   assign p.pin_out = out_r;
   assign p.pin_oe  = oe_r;

   a_od_float: assert property (
      @(posedge clk) disable iff (!rstn)
      (p.drive_mode && !p.active) |=> !p.pin_oe)
      else $error("open-drain pin driven while idle");

   a_pin_level: assert property (
      @(posedge clk) disable iff (!rstn)
      (p.enable && p.active) |=> (p.pin_oe && p.pin_out != $past(p.polarity)))
      else $error("asserted pin level wrong");

endmodule

/* File: core/clock_ratio_meter.sv */
// counts fast clock edges across two slow clock periods
// assumes both clock inputs are sampled levels, synchronous to clk
module clock_ratio_meter
   import sysreg_pkg::*;
#(
   parameter int CNT_W = RATIO_W
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             enable,
   input  wire logic             fast_in,
   input  wire logic             slow_in,
   output logic      [CNT_W-1:0] ratio
);

   initial begin
      if (CNT_W < 2) $error("CNT_W too small");
   end

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARM   = 2'b01,
      ST_COUNT = 2'b10
   } meter_t;

   meter_t           st_r, st_nxt;
   logic             fast_d_r, slow_d_r;
   logic [CNT_W-1:0] cnt_r, ratio_r;
   logic [1:0]       per_r;
   wire              fast_rise = fast_in & ~fast_d_r;
   wire              slow_rise = slow_in & ~slow_d_r;
   wire              last_per  = slow_rise && (per_r == SLOW_PERIODS - 2'h1);
   wire              cnt_max   = &cnt_r;

   // sequencer: idle, wait for slow edge, count
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:  if (enable) st_nxt = ST_ARM;
         ST_ARM:   if (!enable) st_nxt = ST_IDLE;
                   else if (slow_rise) st_nxt = ST_COUNT;
         ST_COUNT: if (!enable) st_nxt = ST_IDLE;
         default:  st_nxt = ST_IDLE;
      endcase
   end

   // edge history, period and fast-edge counters
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r     <= ST_IDLE;
         fast_d_r <= 1'b0;
         slow_d_r <= 1'b0;
         cnt_r    <= '0;
         per_r    <= 2'h0;
      end else begin
         st_r     <= st_nxt;
         fast_d_r <= fast_in;
         slow_d_r <= slow_in;
         if (st_r != ST_COUNT || last_per) begin
            cnt_r <= '0;
            per_r <= 2'h0;
         end else begin
            if (fast_rise && !cnt_max) cnt_r <= cnt_r + 1'b1;
            if (slow_rise) per_r <= per_r + 2'h1;
         end
      end
   end

   // result capture
   // the result is kept after the enable drops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ratio_r <= '0;
      else if (st_r == ST_COUNT && enable && last_per) ratio_r <= cnt_r;
   end

   assign ratio = ratio_r;

   a_ratio_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      !enable |=> $stable(ratio))
      else $error("ratio changed while measuring is off");

   c_ratio_done: cover property (
      @(posedge clk) disable iff (!rstn)
      st_r == ST_COUNT && last_per && enable);

endmodule

/* File: core/system_pin_regs.sv */
// system register group: auxiliary pins, fifo threshold, identity,
// bus target address and clock ratio
// assumes a serial control port front end that presents decoded
// register reads and writes, one access per strobe, 16-bit data
// Functional notes
// - aux1 drive bit 0 drives always; 1 drives only while asserted
// - aux1 polarity 0 asserts high, 1 asserts low
// - aux0 enable 0 floats the pin; status flags keep updating
// - aux0 drive bit 0 drives always; 1 drives only while asserted
// - aux0 polarity 0 asserts high, 1 asserts low
// - fifo interrupt raised while stored words exceed six-bit threshold
// - fifo interrupt drops by itself once words no longer exceed threshold
// - target address written only when the upper byte carries the key
// - seven-bit bus target address is read/write, resets to default
// - when enabled, count fast cycles over two slow periods into 12 bits
// - aux1 function 0x00 is the legacy default mode
// - aux1 function 0x01 shows the masked interrupt output
// - aux1 function 0x02 asserts from first slot start to last slot end
// - aux1 functions 0x05, 0x06, 0x07 show slot A, B, both pulses
// - aux1 functions 0x0C, 0x0D, 0x0E show data cycles A, B, any
// - fifo interrupt enabled only with mask 0; mask resets to 1
// - slot flags set on event, clear on write of 1 only
module system_pin_regs
   import sysreg_pkg::*;
#(
   parameter int         WC_W      = 7,
   parameter logic [7:0] REV_CODE  = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'hC3  // arbitrary value
) (
   input  wire logic              CLK,
   input  wire logic              RSTN,
   input  wire logic [7:0]        REG_ADDR,
   input  wire logic              REG_WR,
   input  wire logic [15:0]       REG_WDATA,
   input  wire logic              REG_RD,
   output logic      [15:0]       REG_RDATA,
   input  wire logic [WC_W-1:0]   FIFO_WORDS,
   input  wire logic              SLOT_A_EVENT,
   input  wire logic              SLOT_B_EVENT,
   input  wire logic              SLOTS_ACTIVE,
   input  wire logic              PULSE_A,
   input  wire logic              PULSE_B,
   input  wire logic              DATA_CYCLE_A,
   input  wire logic              DATA_CYCLE_B,
   input  wire logic              FAST_CLK_IN,
   input  wire logic              SLOW_CLK_IN,
   output logic                   AUX0_OUT,
   output logic                   AUX0_OE,
   output logic                   AUX1_OUT,
   output logic                   AUX1_OE,
   output logic                   FIFO_FLUSH,
   output logic      [ADDR_W-1:0] BUS_TARGET_ADDR
);

   initial begin
      if (WC_W < THR_W || WC_W > 8) $error("WC_W out of range");
   end

   // all assertions below share this clock and reset
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   // register storage
   logic              slot_a_flag_r, slot_b_flag_r;
   logic [8:0]        mask_r;
   logic              aux1_drv_r, aux1_pol_r;
   logic              aux0_en_r, aux0_drv_r, aux0_pol_r;
   logic [THR_W-1:0]  thr_r;
   logic [ADDR_W-1:0] bus_addr_r;
   logic              ratio_en_r;
   logic [FN_W-1:0]   aux1_fn_r;
   logic              toggle_r;
   logic              flush_r;
   logic [15:0]       rdata_r;
   logic [RATIO_W-1:0] ratio;

   // address decode
   wire wr_status = REG_WR && REG_ADDR == OFS_STATUS;
   wire wr_mask   = REG_WR && REG_ADDR == OFS_MASK;
   wire wr_aux    = REG_WR && REG_ADDR == OFS_AUX_CTL;
   wire wr_thr    = REG_WR && REG_ADDR == OFS_FIFO_THR;
   wire wr_addr   = REG_WR && REG_ADDR == OFS_BUS_ADDR;
   wire wr_fn     = REG_WR && REG_ADDR == OFS_AUX1_FN;
   wire wr_rctl   = REG_WR && REG_ADDR == OFS_RATIO_CTL;
   wire key_ok    = REG_WDATA[KEY_LSB +: 8] == ADDR_KEY;

   // interrupt conditions and their combined level
   // live word compare, no latch
   wire [WC_W-1:0] thr_ext   = WC_W'(thr_r);
   wire fifo_over   = FIFO_WORDS > thr_ext;
   wire fifo_irq    = fifo_over & ~mask_r[B_FIFO_MASK];
   wire slot_a_irq  = slot_a_flag_r & ~mask_r[B_SLOT_A];
   wire slot_b_irq  = slot_b_flag_r & ~mask_r[B_SLOT_B];
   wire irq_any     = fifo_irq | slot_a_irq | slot_b_irq;
   wire data_any    = DATA_CYCLE_A | DATA_CYCLE_B;
   // sources passed as an argument so the decode follows each of them
   wire [4:0] fn_src = {DATA_CYCLE_B, DATA_CYCLE_A, PULSE_B, PULSE_A, SLOTS_ACTIVE};

   // second pin function decode
   function automatic logic fn_level(input logic [FN_W-1:0] fn,
                                     input logic irq,
                                     input logic tgl,
                                     input logic [4:0] src);
      case (aux1_func_t'(fn))
         FN_LEGACY:   fn_level = irq;
         FN_IRQ:      fn_level = irq;
         FN_SLOTS:    fn_level = src[0];
         FN_PULSE_A:  fn_level = src[1];
         FN_PULSE_B:  fn_level = src[2];
         FN_PULSE_AB: fn_level = src[1] | src[2];
         FN_DATA_A:   fn_level = src[3];
         FN_DATA_B:   fn_level = src[4];
         FN_DATA_ANY: fn_level = src[3] | src[4];
         FN_TOGGLE:   fn_level = tgl;
         FN_LOW:      fn_level = 1'b0;
         FN_HIGH:     fn_level = 1'b1;
         default:     fn_level = 1'b0;
      endcase
   endfunction

   // through picked by the same decode
   wire aux1_active = fn_level(aux1_fn_r, irq_any, toggle_r, fn_src);

   // read data selection
   // identity bytes read as constants
   wire [15:0] rd_mux =
      (REG_ADDR == OFS_STATUS)    ? {8'(FIFO_WORDS) << 1, 1'b0, slot_b_flag_r,
                                     slot_a_flag_r, 5'h00} :
      (REG_ADDR == OFS_MASK)      ? {7'h00, mask_r} :
      (REG_ADDR == OFS_AUX_CTL)   ? {6'h00, aux1_drv_r, aux1_pol_r, 5'h00,
                                     aux0_en_r, aux0_drv_r, aux0_pol_r} :
      (REG_ADDR == OFS_FIFO_THR)  ? {2'h0, thr_r, 8'h00} :
      (REG_ADDR == OFS_IDENT)     ? {REV_CODE, PART_CODE} :
      (REG_ADDR == OFS_BUS_ADDR)  ? {8'h00, bus_addr_r, 1'b0} :
      (REG_ADDR == OFS_RATIO)     ? {4'h0, ratio} :
      (REG_ADDR == OFS_AUX1_FN)   ? {3'h0, aux1_fn_r, 8'h00} :
      (REG_ADDR == OFS_RATIO_CTL) ? {10'h000, ratio_en_r, 5'h00} :
                                    16'h0000;

   // sticky slot flags
   // a new event in the clearing cycle keeps the flag set
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         slot_a_flag_r <= 1'b0;
         slot_b_flag_r <= 1'b0;
      end else begin
         slot_a_flag_r <= SLOT_A_EVENT |
                          (slot_a_flag_r & ~(wr_status & REG_WDATA[B_SLOT_A]));
         slot_b_flag_r <= SLOT_B_EVENT |
                          (slot_b_flag_r & ~(wr_status & REG_WDATA[B_SLOT_B]));
      end
   end

   // interrupt masks, all disabled out of reset
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) mask_r <= MASK_RST;
      else if (wr_mask) mask_r <= REG_WDATA[8:0];
   end

   // pin control bits
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         {aux1_drv_r, aux1_pol_r} <= 2'h0;
         {aux0_en_r, aux0_drv_r, aux0_pol_r} <= 3'h0;
      end else if (wr_aux) begin
         aux1_drv_r <= REG_WDATA[B_AUX1_DRV];
         aux1_pol_r <= REG_WDATA[B_AUX1_POL];
         aux0_en_r  <= REG_WDATA[B_AUX0_EN];
         aux0_drv_r <= REG_WDATA[B_AUX0_DRV];
         aux0_pol_r <= REG_WDATA[B_AUX0_POL];
      end
   end

   // fifo threshold, second pin function, ratio enable
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         thr_r      <= '0;
         aux1_fn_r  <= '0;
         ratio_en_r <= 1'b0;
      end else begin
         if (wr_thr) thr_r <= REG_WDATA[THR_LSB +: THR_W];
         if (wr_fn) aux1_fn_r <= REG_WDATA[FN_LSB +: FN_W];
         if (wr_rctl) ratio_en_r <= REG_WDATA[B_RATIO_EN];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) bus_addr_r <= BUS_ADDR_RST;
      else if (wr_addr && key_ok) bus_addr_r <= REG_WDATA[ADDR_LSB +: ADDR_W];
   end

   // sample toggle, fifo flush pulse, read data
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         toggle_r <= 1'b0;
         flush_r  <= 1'b0;
         rdata_r  <= 16'h0000;
      end else begin
         if (data_any) toggle_r <= ~toggle_r;
         flush_r <= wr_status & REG_WDATA[B_FIFO_FLUSH];
         if (REG_RD) rdata_r <= rd_mux;
      end
   end

   // pin drivers
   aux_pin_if aux0 ();
   aux_pin_if aux1 ();

   // first pin gated by its enable
   // first pin shows the combined interrupt level; second pin shows the level picked by its function
   assign aux0.enable     = aux0_en_r;
   assign aux0.drive_mode = aux0_drv_r;
   assign aux0.polarity   = aux0_pol_r;
   assign aux0.active     = irq_any;
   assign aux1.enable     = 1'b1;
   assign aux1.drive_mode = aux1_drv_r;
   assign aux1.polarity   = aux1_pol_r;
   assign aux1.active     = aux1_active;

   aux_pin_drive u_aux0 (
      .clk  (CLK),
      .rstn (RSTN),
      .p    (aux0.drv)
   );

   aux_pin_drive u_aux1 (
      .clk  (CLK),
      .rstn (RSTN),
      .p    (aux1.drv)
   );

   clock_ratio_meter #(
      .CNT_W (RATIO_W)
   ) u_meter (
      .clk     (CLK),
      .rstn    (RSTN),
      .enable  (ratio_en_r),
      .fast_in (FAST_CLK_IN),
      .slow_in (SLOW_CLK_IN),
      .ratio   (ratio)
   );

   // outputs
   assign AUX0_OUT        = aux0.pin_out;
   assign AUX0_OE         = aux0.pin_oe;
   assign AUX1_OUT        = aux1.pin_out;
   assign AUX1_OE         = aux1.pin_oe;
   assign FIFO_FLUSH      = flush_r;
   assign REG_RDATA       = rdata_r;
   assign BUS_TARGET_ADDR = bus_addr_r;

   a_fifo_irq_rise: assert property (
      (!mask_r[B_FIFO_MASK] && FIFO_WORDS > thr_ext && aux0_en_r && !aux0_drv_r)
      |=> AUX0_OE && AUX0_OUT != $past(aux0_pol_r))
      else $error("fifo interrupt missing on first pin");

   a_fifo_irq_drop: assert property (
      (FIFO_WORDS <= thr_ext && !slot_a_irq && !slot_b_irq && aux0_en_r)
      |=> AUX0_OUT == $past(aux0_pol_r))
      else $error("fifo interrupt held without cause");

   a_fifo_masked: assert property (
      (mask_r[B_FIFO_MASK] && !slot_a_flag_r && !slot_b_flag_r) |-> !irq_any)
      else $error("masked fifo interrupt seen");

   a_aux0_floats: assert property (
      !aux0_en_r |=> !AUX0_OE)
      else $error("disabled first pin driven");

   a_aux1_push: assert property (
      !aux1_drv_r |=> AUX1_OE)
      else $error("push-pull second pin not driven");

   a_aux1_slots: assert property (
      (aux1_fn_r == FN_SLOTS && !aux1_drv_r)
      |=> AUX1_OUT == ($past(SLOTS_ACTIVE) ^ $past(aux1_pol_r)))
      else $error("slot window not shown on second pin");

   a_aux1_pulse_ab: assert property (
      (aux1_fn_r == FN_PULSE_AB && (PULSE_A || PULSE_B) && !aux1_pol_r)
      |=> AUX1_OUT)
      else $error("slot pulse not shown on second pin");

   a_key_guard: assert property (
      (wr_addr && !key_ok) |=> $stable(BUS_TARGET_ADDR))
      else $error("target address changed without key");

   a_key_write: assert property (
      (wr_addr && key_ok)
      |=> BUS_TARGET_ADDR == $past(REG_WDATA[ADDR_LSB +: ADDR_W]))
      else $error("keyed target address write lost");

   a_slot_sticky: assert property (
      (slot_a_flag_r && !(wr_status && REG_WDATA[B_SLOT_A])) |=> slot_a_flag_r)
      else $error("slot flag dropped without clear");

   a_ident_read: assert property (
      (REG_RD && REG_ADDR == OFS_IDENT) |=> REG_RDATA == {REV_CODE, PART_CODE})
      else $error("identity read wrong");

   c_key_write: cover property (wr_addr && key_ok);
   c_aux1_float: cover property (aux1_drv_r && !AUX1_OE);
   c_slot_clear: cover property (slot_a_flag_r ##1 !slot_a_flag_r);

endmodule

/* File: verif/reg_host_model.sv */
// host side of the serial control port: one register access per task call
// assumes the register group takes a strobe at the rising edge after it rises
module reg_host_model (
   input  wire logic        clk,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic      [15:0] reg_wdata,
   output logic             reg_rd,
   input  wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle port at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd    = 1'b0;
   end

   // key byte sent only within an address write
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;  // released lines never show the old value
      reg_wdata <= ~d;
   endtask

   // read data is loaded at the taking edge, picked up once settled
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(negedge clk);
      d = reg_rdata;
   endtask
endmodule

/* File: verif/test_system_pin_and_id_registers.sv */
// self-checking bench for the system pin and identification register group
// assumes the host model owns the register port; core-side inputs come from here
module test_system_pin_and_id_registers
   import sysreg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] REV_T  = 8'h3C; // arbitrary value
   localparam logic [7:0] PART_T = 8'hA5; // arbitrary value

   logic        clk, rstn, reg_wr, reg_rd, ev_a, ev_b, fast_in, slow_in;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, cyc;
   logic [6:0]  words;
   logic [4:0]  src;  // data_b, data_a, pulse_b, pulse_a, slots_active
   logic        aux0_out, aux0_oe, aux1_out, aux1_oe, flush;
   logic [6:0]  bus_addr;
   int          err_total, n_compared;

   reg_host_model i_reg_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   system_pin_regs #(.REV_CODE(REV_T), .PART_CODE(PART_T)) i_system_pin_regs (
      .CLK(clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .FIFO_WORDS(words), .SLOT_A_EVENT(ev_a), .SLOT_B_EVENT(ev_b),
      .SLOTS_ACTIVE(src[0]), .PULSE_A(src[1]), .PULSE_B(src[2]),
      .DATA_CYCLE_A(src[3]), .DATA_CYCLE_B(src[4]), .FAST_CLK_IN(fast_in),
      .SLOW_CLK_IN(slow_in), .AUX0_OUT(aux0_out), .AUX0_OE(aux0_oe),
      .AUX1_OUT(aux1_out), .AUX1_OE(aux1_oe), .FIFO_FLUSH(flush),
      .BUS_TARGET_ADDR(bus_addr));

   // clock and stimulus clocks: fast period 4 cycles, slow period 64 cycles
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc     <= rstn ? cyc + 16'h0001 : 16'h0000;
      fast_in <= cyc[1];
      slow_in <= cyc[5];
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      i_reg_host_model.rd(a, d);
      chk(d, exp, "register read");
   endtask

   task automatic settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   // driven unless open drain with no interrupt; level is irq after polarity
   task automatic pin_chk(input logic drv, pol, irq, oe, out, input string what);
      logic exp_oe;
      exp_oe = !drv || irq;
      chk({15'h0, oe}, {15'h0, exp_oe}, what);
      if (exp_oe) chk({15'h0, out}, {15'h0, irq ^ pol}, what);
   endtask

   task automatic t_reset;
      chk({9'h0, bus_addr}, 16'h0064, "target address pin");
      pin_chk(1'b0, 1'b0, 1'b0, aux1_oe, aux1_out, "aux1 after reset");
      chk({15'h0, aux0_oe}, 16'h0000, "aux0 floats after reset");
      rchk(OFS_AUX_CTL, 16'h0000);
      rchk(OFS_FIFO_THR, 16'h0000);
      rchk(OFS_IDENT, {REV_T, PART_T});
      i_reg_host_model.wr(OFS_IDENT, 16'hFFFF);
      rchk(OFS_IDENT, {REV_T, PART_T});
      rchk(OFS_BUS_ADDR, 16'h00C8);
      i_reg_host_model.wr(OFS_RATIO, 16'h0FFF);
      rchk(OFS_RATIO, 16'h0000);
      rchk(OFS_AUX1_FN, 16'h0000);
      rchk(OFS_MASK, 16'h01FF);
      rchk(8'h3F, 16'h0000);
      $display("test reset values done");
   endtask

   task automatic t_addr_key;
      i_reg_host_model.wr(OFS_BUS_ADDR, 16'h1222);
      settle;
      chk({9'h0, bus_addr}, 16'h0064, "address kept without key");
      rchk(OFS_BUS_ADDR, 16'h00C8);
      i_reg_host_model.wr(OFS_BUS_ADDR, {ADDR_KEY, 8'h22});
      settle;
      chk({9'h0, bus_addr}, 16'h0011, "address written with key");
      rchk(OFS_BUS_ADDR, 16'h0022);
      $display("test address key done");
   endtask

   task automatic t_pins;
      logic irq, d0, p0, d1, p1;
      i_reg_host_model.wr(OFS_MASK, 16'h00FF);
      i_reg_host_model.wr(OFS_FIFO_THR, 16'h0400);
      for (int v = 0; v < 32; v++) begin
         {p1, d1, p0, d0, irq} = v[4:0];
         @(posedge clk) words <= irq ? 7'd5 : 7'd4;
         i_reg_host_model.wr(OFS_AUX_CTL, {6'h0, d1, p1, 5'h0, 1'b1, d0, p0});
         settle;
         pin_chk(d0, p0, irq, aux0_oe, aux0_out, "aux0 pin");
         pin_chk(d1, p1, irq, aux1_oe, aux1_out, "aux1 pin");
      end
      i_reg_host_model.wr(OFS_AUX_CTL, 16'h0000);
      settle;
      chk({15'h0, aux0_oe}, 16'h0000, "aux0 disabled");
      rchk(OFS_STATUS, 16'h0A00);
      i_reg_host_model.wr(OFS_AUX1_FN, 16'h0100);
      settle;
      chk({15'h0, aux1_out}, 16'h0001, "interrupt function");
      i_reg_host_model.wr(OFS_MASK, 16'h01FF);
      settle;
      chk({15'h0, aux1_out}, 16'h0000, "fifo interrupt masked");
      i_reg_host_model.wr(OFS_MASK, 16'h00FF);
      i_reg_host_model.wr(OFS_FIFO_THR, 16'h3F00);
      for (int w = 63; w < 65; w++) begin
         @(posedge clk) words <= 7'(w);
         settle;
         chk({15'h0, aux1_out}, {15'h0, w == 64}, "threshold top");
      end
      $display("test pin control done");
   endtask

   task automatic t_slots;
      @(posedge clk) words <= 7'd0;
      i_reg_host_model.wr(OFS_MASK, 16'h01DF);
      i_reg_host_model.wr(OFS_AUX1_FN, 16'h0000);
      @(posedge clk) {ev_b, ev_a} <= 2'b11;
      @(posedge clk) {ev_b, ev_a} <= 2'b00;
      settle;
      chk({15'h0, aux1_out}, 16'h0001, "slot interrupt on pin");
      rchk(OFS_STATUS, 16'h0060);
      i_reg_host_model.wr(OFS_STATUS, 16'h0000);
      rchk(OFS_STATUS, 16'h0060);
      i_reg_host_model.wr(OFS_STATUS, 16'h0020);
      rchk(OFS_STATUS, 16'h0040);
      settle;
      chk({15'h0, aux1_out}, 16'h0000, "masked slot flag off pin");
      i_reg_host_model.wr(OFS_STATUS, 16'h0040);
      i_reg_host_model.wr(OFS_MASK, 16'h01FF);
      i_reg_host_model.wr(OFS_STATUS, 16'h8000);
      @(negedge clk) chk({15'h0, flush}, 16'h0001, "flush pulse");
      @(negedge clk) chk({15'h0, flush}, 16'h0000, "flush pulse ends");
      $display("test slot flags done");
   endtask

   task automatic t_functions;
      logic [4:0] codes [10] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h07,
                                 5'h0C, 5'h0D, 5'h0E, 5'h10, 5'h11};
      logic [4:0] hit [10] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h06,
                               5'h08, 5'h10, 5'h18, 5'h00, 5'h1F};
      logic       lvl;
      i_reg_host_model.wr(OFS_AUX1_FN, 16'h0F00);
      settle;
      lvl = aux1_out;
      @(posedge clk) src <= 5'h08;
      @(posedge clk) src <= 5'h00;
      settle;
      chk({15'h0, aux1_out}, {15'h0, ~lvl}, "toggle function");
      for (int i = 0; i < 10; i++) begin
         i_reg_host_model.wr(OFS_AUX1_FN, {3'h0, codes[i], 8'h00});
         for (int b = 0; b < 5; b++) begin
            @(posedge clk) src <= 5'h01 << b;
            settle;
            chk({15'h0, aux1_out}, {15'h0, hit[i][b]}, "aux1 function");
         end
         @(posedge clk) src <= 5'h00;
      end
      rchk(OFS_AUX1_FN, 16'h1100);
      $display("test aux1 functions done");
   endtask

   task automatic t_ratio;
      i_reg_host_model.wr(OFS_RATIO_CTL, 16'h0020);
      repeat (400) @(posedge clk);
      rchk(OFS_RATIO, 16'h0020);
      $display("test clock ratio done");
   endtask

   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      {rstn, ev_a, ev_b, src, words} = '0;
      err_total  = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      settle;
      t_reset;
      t_addr_key;
      t_pins;
      t_slots;
      t_functions;
      t_ratio;
      wrap_up;
   end

   // hang guard
   initial begin
      repeat (50000) @(posedge clk);
      err_total++;
      $display("[FAIL] t=%0t run did not finish", $time);
      wrap_up;
   end
endmodule
